// [rtl/iscd_pkg.sv]
// Shared constants and types for the two-wire slave control block
package iscd_pkg;
   localparam int          REG_AW      = 32;
   localparam int          REG_DW      = 16;
   localparam logic [31:0] ADR_DIV     = 32'hFFFF08A4;
   localparam logic [31:0] ADR_SCTL    = 32'hFFFF08A8;
   localparam logic [31:0] ADR_SSTA    = 32'hFFFF08AC;
   localparam logic [31:0] ADR_ALT     = 32'hFFFF08B0;
   localparam logic [31:0] ADR_OWN     = 32'hFFFF08B4;
   localparam logic [31:0] ADR_TXD     = 32'hFFFF08B8;
   localparam logic [31:0] ADR_RXD     = 32'hFFFF08BC;
   localparam logic [31:0] ADR_IRQ_STA = 32'hFFFF08C0;
   localparam logic [31:0] ADR_IRQ_EN  = 32'hFFFF08C4;
   localparam logic [31:0] ADR_IRQ_CLR = 32'hFFFF08C8;
   localparam logic [31:0] ADR_MCTL    = 32'hFFFF08CC;
   localparam logic [15:0] DIV_RST     = 16'h1F1F;
   localparam logic [15:0] SCTL_RST    = 16'h0000;
   localparam logic [15:0] SCTL_WMASK  = 16'h07AD;
   localparam logic [7:0]  BYTE_RST    = 8'h00;
   localparam logic [6:0]  OWN_RST     = 7'h00;
   localparam int          B_TXIE      = 10;
   localparam int          B_RXIE      = 9;
   localparam int          B_SSIE      = 8;
   localparam int          B_NACK      = 7;
   localparam int          B_ETX       = 5;
   localparam int          B_GCCLR     = 4;
   localparam int          B_HGC       = 3;
   localparam int          B_GC        = 2;
   localparam int          B_SEN       = 0;
   localparam int          CLOCK_HIGH_COUNT_MSB    = 15;
   localparam int          CLOCK_HIGH_COUNT_LSB    = 8;
   localparam int          CLOCK_LOW_COUNT_MSB    = 7;
   localparam int          CLOCK_LOW_COUNT_LSB    = 0;
   localparam int          NEV         = 6;
   localparam int          EV_TXDONE   = 0;
   localparam int          EV_RX       = 1;
   localparam int          EV_STOP     = 2;
   localparam int          EV_TXREQ    = 3;
   localparam int          EV_GC       = 4;
   localparam int          EV_HGC      = 5;
   localparam int          SS_GC       = 0;
   localparam int          SS_HGC      = 1;
   localparam int          SS_ID       = 2;
   localparam int          SS_BUSY     = 3;
   localparam logic [7:0]  GC_ADDR     = 8'h00;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   localparam logic [3:0]  LAST_BIT    = 4'h7;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b010,
      ST_RX   = 3'b011,
      ST_RACK = 3'b100,
      ST_TX   = 3'b101,
      ST_TACK = 3'b110
   } iscd_state_t;
endpackage : iscd_pkg

// [rtl/iscd_scl_div.sv]
// Serial clock generator timing high and low phases in clock cycles
`timescale 1ns/1ps
module iscd_scl_div
   import iscd_pkg::*;
#(
   parameter int CW = 8
) (
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          run,
   input  wire logic [CW-1:0] high_count,
   input  wire logic [CW-1:0] low_count,
   output logic               scl_low
);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] lim;
   logic          high_r;

   assign lim = high_r ? high_count : low_count;

   // A zero count still gives a one-cycle phase
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r  <= '0;
         high_r <= 1'b1;
      end else if (!run) begin
         cnt_r  <= '0;
         high_r <= 1'b1;
      end else if (lim == '0 || cnt_r >= lim - CW'(1)) begin
         cnt_r  <= '0;
         high_r <= ~high_r;
      end else begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   assign scl_low = ~high_r;
endmodule : iscd_scl_div

// [rtl/iscd_slave_ctrl.sv]
// Two-wire slave control, clock divider and register file
// Overview of operation
// - Serial clock high phase length comes from divider bits 15:8.
// - Serial clock low phase length comes from divider bits 7:0.
// - Slave transmit byte done raises interrupt only when bit 10 set.
// - Slave receive data raises interrupt only when bit 9 set.
// - Stop condition detection raises interrupt only when bit 8 set.
// - Force not-acknowledge bit makes the slave refuse every address and data byte while it is set.
// - Early bit moves transmit request from falling to rising edge of read bit.
// - Writing one to general call clear wipes general call status and ID.
// - Both general call enables: match first data byte against alternate address.
// - General call enable lets slave acknowledge address 0x00, else ignored.
// - Slave works on the bus only while slave enable is set.
`timescale 1ns/1ps
module iscd_slave_ctrl
   import iscd_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic [REG_DW-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [REG_DW-1:0]      reg_rdata,
   output logic                   irq,
   input  wire logic              scl_i,
   output logic                   scl_o,
   output logic                   scl_oe,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe
);
   logic [15:0]    div_r;
   logic [15:0]    sctl_r;
   logic [7:0]     alt_r;
   logic [6:0]     own_r;
   logic [7:0]     txd_r;
   logic [7:0]     rxd_r;
   logic [NEV-1:0] irq_sta_r;
   logic [NEV-1:0] irq_en_r;
   logic           mctl_r;
   logic           gc_r;
   logic           hgc_r;
   logic           id_r;
   logic           busy_r;
   logic [15:0]    rdata_r;
   logic [2:0]     scl_sy_r;
   logic [2:0]     sda_sy_r;
   iscd_state_t    st_r;
   logic [3:0]     bit_r;
   logic [7:0]     sh_r;
   logic           rw_r;
   logic           mnak_r;
   logic           gct_r;
   logic           sda_drv_r;

   logic           scl_rise;
   logic           scl_fall;
   logic           start_det;
   logic           stop_det;
   logic           sen;
   logic           run;
   logic           nack;
   logic           gc_hit;
   logic           own_hit;
   logic           addr_ok;
   logic           byte_end;
   logic           ev_txdone;
   logic           ev_rx;
   logic           ev_stop;
   logic           ev_txreq;
   logic           ev_gc;
   logic           ev_hgc;
   logic           gc_clr;
   logic [NEV-1:0] sta_set;
   logic [15:0]    rd_mux;

   function automatic logic wr_at(input logic [31:0] a);
      return reg_wr && reg_addr == a;
   endfunction : wr_at

   // Pins cross into the clock domain through two flops first
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_sy_r <= 3'h7;
         sda_sy_r <= 3'h7;
      end else begin
         scl_sy_r <= {scl_sy_r[1:0], scl_i};
         sda_sy_r <= {sda_sy_r[1:0], sda_i};
      end
   end

   assign scl_rise  = scl_sy_r[1] & ~scl_sy_r[2];
   assign scl_fall  = ~scl_sy_r[1] & scl_sy_r[2];
   assign start_det = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[2] & ~sda_sy_r[1];
   assign stop_det  = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[2] & sda_sy_r[1];

   assign sen      = sctl_r[B_SEN];
   assign nack     = sctl_r[B_NACK];
   assign run      = sen & ~start_det & ~stop_det;
   assign gc_hit   = sctl_r[B_GC] && sh_r == GC_ADDR;
   assign own_hit  = sh_r[7:1] == own_r;
   assign addr_ok  = (own_hit | gc_hit) & ~nack;
   assign byte_end = scl_fall && bit_r == BYTE_BITS;

   // Slave bit engine: sample on rising clock, change data on falling
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r      <= ST_IDLE;
         bit_r     <= 4'h0;
         sh_r      <= 8'h00;
         rw_r      <= 1'b0;
         mnak_r    <= 1'b0;
         gct_r     <= 1'b0;
         sda_drv_r <= 1'b0;
      end else if (!sen || stop_det) begin
         st_r      <= ST_IDLE;
         sda_drv_r <= 1'b0;
      end else if (start_det) begin
         st_r      <= ST_ADDR;
         bit_r     <= 4'h0;
         sda_drv_r <= 1'b0;
      end else begin
         case (st_r)
            ST_ADDR: begin
               if (scl_rise) begin
                  sh_r  <= {sh_r[6:0], sda_sy_r[2]};
                  bit_r <= bit_r + 4'h1;
               end else if (byte_end) begin
                  bit_r <= 4'h0;
                  if (addr_ok) begin
                     st_r      <= ST_AACK;
                     sda_drv_r <= 1'b1;
                     rw_r      <= sh_r[0];
                     gct_r     <= gc_hit;
                  end else begin
                     // Unclaimed or refused: leave the bus alone until next start
                     st_r <= ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  bit_r <= 4'h0;
                  if (rw_r) begin
                     st_r      <= ST_TX;
                     sh_r      <= txd_r;
                     sda_drv_r <= ~txd_r[7];
                  end else begin
                     st_r      <= ST_RX;
                     sda_drv_r <= 1'b0;
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  sh_r  <= {sh_r[6:0], sda_sy_r[2]};
                  bit_r <= bit_r + 4'h1;
               end else if (byte_end) begin
                  st_r      <= ST_RACK;
                  bit_r     <= 4'h0;
                  sda_drv_r <= ~nack;
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  st_r      <= ST_RX;
                  sda_drv_r <= 1'b0;
                  gct_r     <= 1'b0;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_r == LAST_BIT) begin
                     st_r      <= ST_TACK;
                     sda_drv_r <= 1'b0;
                     bit_r     <= 4'h0;
                  end else begin
                     sh_r      <= {sh_r[6:0], 1'b0};
                     sda_drv_r <= ~sh_r[6];
                     bit_r     <= bit_r + 4'h1;
                  end
               end
            end
            ST_TACK: begin
               if (scl_rise) begin
                  mnak_r <= sda_sy_r[2];
               end else if (scl_fall) begin
                  if (mnak_r) begin
                     st_r <= ST_IDLE;
                  end else begin
                     st_r      <= ST_TX;
                     sh_r      <= txd_r;
                     sda_drv_r <= ~txd_r[7];
                  end
               end
            end
            default: begin
               st_r      <= ST_IDLE;
               sda_drv_r <= 1'b0;
            end
         endcase
      end
   end

   assign sda_o  = 1'b0;
   assign sda_oe = sda_drv_r;

   // Bus events, each a single-cycle pulse
   assign ev_rx     = run && st_r == ST_RX && byte_end;
   assign ev_txdone = run && st_r == ST_TX && scl_fall && bit_r == LAST_BIT;
   assign ev_stop   = stop_det & sen & busy_r;
   assign ev_gc     = run && st_r == ST_ADDR && byte_end && addr_ok && gc_hit;
   assign ev_hgc    = ev_rx && gct_r && sctl_r[B_HGC] && sctl_r[B_GC] && sh_r == alt_r;
   always_comb begin
      ev_txreq = 1'b0;
      if (sctl_r[B_ETX]) begin
         // Early: on the rising edge that samples a read bit
         ev_txreq = run && st_r == ST_ADDR && scl_rise && bit_r == LAST_BIT && sda_sy_r[2]
                    && sh_r[6:0] == own_r && !nack;
      end else begin
         ev_txreq = run && st_r == ST_ADDR && byte_end && sh_r[0] && own_hit && !nack;
      end
      if (run && st_r == ST_TACK && scl_fall && !mnak_r) begin
         ev_txreq = 1'b1;
      end
   end

   // Stop, receive and transmit-done sources are gated by the slave control enables before they stick
   assign sta_set = {ev_hgc, ev_gc, ev_txreq, ev_stop & sctl_r[B_SSIE],
                     ev_rx & sctl_r[B_RXIE],
                     ev_txdone & sctl_r[B_TXIE]};

   // Sticky interrupt status; an event in the clearing cycle survives
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_sta_r <= '0;
      end else begin
         irq_sta_r <= (irq_sta_r & ~(wr_at(ADR_IRQ_CLR) ? reg_wdata[NEV-1:0] : '0)) | sta_set;
      end
   end

   assign irq = |(irq_sta_r & irq_en_r);

   // Clear bit is a self-clearing action, never stored; strobe read directly so it drops with reg_wr
   assign gc_clr = reg_wr && reg_addr == ADR_SCTL && reg_wdata[B_GCCLR];

   // Slave status flags; set wins over the clear bit
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gc_r   <= 1'b0;
         hgc_r  <= 1'b0;
         id_r   <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         gc_r  <= ev_gc | (gc_r & ~gc_clr);
         hgc_r <= ev_hgc | (hgc_r & ~gc_clr);
         id_r  <= (run && st_r == ST_ADDR && byte_end && addr_ok && own_hit) | (id_r & ~gc_clr);
         if (stop_det || !sen) begin
            busy_r <= 1'b0;
         end else if (run && st_r == ST_ADDR && byte_end && addr_ok) begin
            busy_r <= 1'b1;
         end
      end
   end

   // Software registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r    <= DIV_RST;
         sctl_r   <= SCTL_RST;
         alt_r    <= BYTE_RST;
         own_r    <= OWN_RST;
         txd_r    <= BYTE_RST;
         irq_en_r <= '0;
         mctl_r   <= 1'b0;
      end else begin
         if (wr_at(ADR_DIV)) begin
            div_r <= reg_wdata;
         end
         if (wr_at(ADR_SCTL)) begin
            // Reserved bits and the clear action are not stored
            sctl_r <= reg_wdata & SCTL_WMASK;
         end
         if (wr_at(ADR_ALT)) begin
            alt_r <= reg_wdata[7:0];
         end
         if (wr_at(ADR_OWN)) begin
            own_r <= reg_wdata[6:0];
         end
         if (wr_at(ADR_TXD)) begin
            txd_r <= reg_wdata[7:0];
         end
         if (wr_at(ADR_IRQ_EN)) begin
            irq_en_r <= reg_wdata[NEV-1:0];
         end
         if (wr_at(ADR_MCTL)) begin
            mctl_r <= reg_wdata[0];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxd_r <= BYTE_RST;
      end else if (ev_rx) begin
         rxd_r <= sh_r;
      end
   end

   always_comb begin
      rd_mux = 16'h0000;
      case (reg_addr)
         ADR_DIV:     rd_mux = div_r;
         ADR_SCTL:    rd_mux = sctl_r;
         ADR_SSTA:    begin
            rd_mux[SS_GC]   = gc_r;
            rd_mux[SS_HGC]  = hgc_r;
            rd_mux[SS_ID]   = id_r;
            rd_mux[SS_BUSY] = busy_r;
         end
         ADR_ALT:     rd_mux = {8'h00, alt_r};
         ADR_OWN:     rd_mux = {9'h000, own_r};
         ADR_TXD:     rd_mux = {8'h00, txd_r};
         ADR_RXD:     rd_mux = {8'h00, rxd_r};
         ADR_IRQ_STA: rd_mux[NEV-1:0] = irq_sta_r;
         ADR_IRQ_EN:  rd_mux[NEV-1:0] = irq_en_r;
         ADR_MCTL:    rd_mux[0] = mctl_r;
         default:     rd_mux = 16'h0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_r;

   iscd_scl_div #(
      .CW (8)
   ) u_div (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .run        (mctl_r),
      .high_count (div_r[CLOCK_HIGH_COUNT_MSB:CLOCK_HIGH_COUNT_LSB]),
      .low_count  (div_r[CLOCK_LOW_COUNT_MSB:CLOCK_LOW_COUNT_LSB]),
      .scl_low    (scl_oe)
   );

   assign scl_o = 1'b0;
endmodule : iscd_slave_ctrl

// [verification/iscd_assertions.sv]
// Port-level assertions for the two-wire slave control block
`timescale 1ns/1ps
module iscd_chk
   import iscd_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [REG_DW-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [REG_DW-1:0] reg_rdata,
   input wire logic              irq,
   input wire logic              scl_i,
   input wire logic              scl_o,
   input wire logic              scl_oe,
   input wire logic              sda_i,
   input wire logic              sda_o,
   input wire logic              sda_oe
);
   logic [15:0] div_r;
   logic [15:0] sctl_r;
   logic        mctl_r;
   logic        prev_r;
   logic        seen_r;
   logic [8:0]  run_r;
   logic [8:0]  hi_len;
   logic [8:0]  lo_len;
   assign hi_len = (div_r[CLOCK_HIGH_COUNT_MSB:CLOCK_HIGH_COUNT_LSB] == 8'h00) ? 9'h001 : {1'b0, div_r[CLOCK_HIGH_COUNT_MSB:CLOCK_HIGH_COUNT_LSB]};
   assign lo_len = (div_r[CLOCK_LOW_COUNT_MSB:CLOCK_LOW_COUNT_LSB] == 8'h00) ? 9'h001 : {1'b0, div_r[CLOCK_LOW_COUNT_MSB:CLOCK_LOW_COUNT_LSB]};
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r  <= DIV_RST;
         sctl_r <= SCTL_RST;
         mctl_r <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == ADR_DIV)
            div_r <= reg_wdata;
         if (reg_addr == ADR_SCTL)
            sctl_r <= reg_wdata & SCTL_WMASK;
         if (reg_addr == ADR_MCTL)
            mctl_r <= reg_wdata[0];
      end
   end
   // Phase run length; first phase after enabling runs on from the idle line, so skip it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= 1'b0;
         seen_r <= 1'b0;
         run_r  <= 9'h000;
      end else begin
         prev_r <= scl_oe;
         seen_r <= mctl_r & (seen_r | (prev_r & ~scl_oe));
         run_r  <= (scl_oe != prev_r) ? 9'h001 : run_r + 9'h001;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_held;
      sda_oe [*8];
   endsequence
   sequence s_quiet;
      !scl_oe [*4];
   endsequence
   property p_div_rd;
      reg_rd && reg_addr == ADR_DIV |=> reg_rdata == div_r;
   endproperty
   a_div_rd: assert property (p_div_rd) else $error("divider readback wrong");
   property p_sctl_rd;
      reg_rd && reg_addr == ADR_SCTL |=> reg_rdata == sctl_r;
   endproperty
   a_sctl_rd: assert property (p_sctl_rd) else $error("control readback wrong");
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
   property p_low_len;
      $fell(scl_oe) && mctl_r |-> run_r == lo_len;
   endproperty
   a_low_len: assert property (p_low_len) else $error("clock low phase length wrong");
   property p_high_len;
      $rose(scl_oe) && seen_r |-> run_r == hi_len;
   endproperty
   a_high_len: assert property (p_high_len) else $error("clock high phase length wrong");
   property p_div_off;
      reg_wr && reg_addr == ADR_MCTL && !reg_wdata[0] |-> ##2 s_quiet;
   endproperty
   a_div_off: assert property (p_div_off) else $error("clock driven while divider off");
   property p_sen_off;
      reg_wr && reg_addr == ADR_SCTL && !reg_wdata[B_SEN] |-> ##2 !sda_oe [*4];
   endproperty
   a_sen_off: assert property (p_sen_off) else $error("data driven while slave off");
   property p_sda_edge;
      $changed(sda_oe) |-> !scl_i;
   endproperty
   a_sda_edge: assert property (p_sda_edge) else $error("data moved while clock high");
   property p_ack_hold;
      $rose(sda_oe) |-> s_held;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("data pull too short");
   property p_irq_mask;
      reg_wr && reg_addr == ADR_IRQ_EN && reg_wdata == 16'h0000 |=> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all sources off");
endmodule : iscd_chk
bind iscd_slave_ctrl iscd_chk u_chk (
   .sys_clk   (sys_clk),
   .sys_rst   (sys_rst),
   .reg_addr  (reg_addr),
   .reg_wdata (reg_wdata),
   .reg_wr    (reg_wr),
   .reg_rd    (reg_rd),
   .reg_rdata (reg_rdata),
   .irq       (irq),
   .scl_i     (scl_i),
   .scl_o     (scl_o),
   .scl_oe    (scl_oe),
   .sda_i     (sda_i),
   .sda_o     (sda_o),
   .sda_oe    (sda_oe)
);

// [verification/iscd_master_model.sv]
// Two-wire bus master model pulling clock and data lines low
`timescale 1ns/1ps
module iscd_master_model (
   input  wire logic sys_clk,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   // Phase length in cycles; raise it for a slow master
   int half = 10;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt
   task automatic start();
      sda_low <= 1'b0;
      wt(half);
      scl_low <= 1'b0;
      wt(half);
      sda_low <= 1'b1;
      wt(half);
      scl_low <= 1'b1;
      wt(3);
   endtask : start
   // Data moves 3 cycles after the fall, so it never races the clock edge
   task automatic bit_x(input logic b, output logic r);
      sda_low <= ~b;
      wt(half);
      scl_low <= 1'b0;
      wt(half);
      r = sda;
      scl_low <= 1'b1;
      wt(3);
   endtask : bit_x
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_x(tx[i], rx[i]);
      bit_x(ack_in, ack);
   endtask : xfer
   task automatic stop();
      sda_low <= 1'b1;
      wt(half);
      scl_low <= 1'b0;
      wt(half);
      sda_low <= 1'b0;
      wt(half);
   endtask : stop
endmodule : iscd_master_model

// [verification/testbench.sv]
// Testbench for the two-wire slave control block
`timescale 1ns/1ps
module testbench import iscd_pkg::*;;
   logic              sys_clk;
   logic              sys_rst;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [REG_DW-1:0] reg_rdata;
   logic              irq;
   logic              scl_o;
   logic              scl_oe;
   logic              sda_o;
   logic              sda_oe;
   logic              m_scl_low;
   logic              m_sda_low;
   logic              irq_scl;
   logic              a;
   logic [7:0]        rx;
   logic [15:0]       divs [2] = '{16'h0305, 16'h0200};
   int                fail_count = 0;
   int                compares = 0;
   wire logic         scl;
   wire logic         sda;
   // Pull-ups: a released line reads high
   assign scl = ~(m_scl_low | (scl_oe & ~scl_o));
   assign sda = ~(m_sda_low | (sda_oe & ~sda_o));
   iscd_slave_ctrl DUT (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .irq       (irq),
      .scl_i     (scl),
      .scl_o     (scl_o),
      .scl_oe    (scl_oe),
      .sda_i     (sda),
      .sda_o     (sda_o),
      .sda_oe    (sda_oe)
   );
   iscd_master_model bm (
      .sys_clk (sys_clk),
      .sda     (sda),
      .scl_low (m_scl_low),
      .sda_low (m_sda_low)
   );
   always @(posedge irq)
      irq_scl = scl;
   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] ad, input logic [15:0] wd);
      @(posedge sys_clk);
      reg_addr  <= ad;
      reg_wdata <= wd;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      // Let the write settle before anyone samples its effect
      @(negedge sys_clk);
   endtask : wr
   task automatic rchk(input logic [31:0] ad, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, exp);
   endtask : rchk
   task automatic wtrans(input logic [7:0] ab, input logic [7:0] db, input logic ack_exp);
      bm.start();
      bm.xfer(ab, 1'b1, rx, a);
      chk({15'h0000, a}, {15'h0000, ack_exp});
      if (a === 1'b0)
         bm.xfer(db, 1'b1, rx, a);
      bm.stop();
   endtask : wtrans
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Whole run is near 4000 cycles, a tenth of the 40000-cycle limit
   initial begin
      #1600000;
      fail_count++;
      give_verdict();
   end
   initial begin
      sys_rst   = 1'b1;
      reg_addr  = 32'h00000000;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rchk(ADR_DIV, DIV_RST);
      rchk(ADR_SCTL, SCTL_RST);
      rchk(32'hFFFF0800, 16'h0000);
      wr(ADR_SCTL, 16'hFFAF);
      rchk(ADR_SCTL, 16'h07AD);
      foreach (divs[i]) begin
         wr(ADR_DIV, divs[i]);
         rchk(ADR_DIV, divs[i]);
         wr(ADR_MCTL, 16'h0001);
         repeat (40) @(posedge sys_clk);
         wr(ADR_MCTL, 16'h0000);
      end
      wr(ADR_OWN, 16'h002A);
      wr(ADR_IRQ_EN, 16'h003F);
      wr(ADR_SCTL, 16'h0301);
      wtrans(8'h54, 8'h5A, 1'b0);
      rchk(ADR_RXD, 16'h005A);
      rchk(ADR_IRQ_STA, 16'h0006);
      chk({15'h0000, irq}, 16'h0001);
      wr(ADR_IRQ_EN, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      wr(ADR_IRQ_EN, 16'h003F);
      wr(ADR_IRQ_CLR, 16'h003F);
      chk({15'h0000, irq}, 16'h0000);
      wr(ADR_SCTL, 16'h0001);
      wtrans(8'h54, 8'h5A, 1'b0);
      wr(ADR_SCTL, 16'h0081);
      wtrans(8'h54, 8'h5A, 1'b1);
      wr(ADR_SCTL, 16'h0000);
      wtrans(8'h54, 8'h5A, 1'b1);
      rchk(ADR_IRQ_STA, 16'h0000);
      wr(ADR_IRQ_EN, 16'h0008);
      wr(ADR_TXD, 16'h00C3);
      for (int e = 0; e < 2; e++) begin
         irq_scl = 1'bx;
         wr(ADR_SCTL, (e == 1) ? 16'h0421 : 16'h0001);
         bm.start();
         bm.xfer(8'h55, 1'b1, rx, a);
         bm.xfer(8'hFF, 1'b1, rx, a);
         bm.stop();
         chk({8'h00, rx}, 16'h00C3);
         chk({15'h0000, irq_scl}, e[15:0]);
         rchk(ADR_IRQ_STA, (e == 1) ? 16'h0009 : 16'h0008);
         wr(ADR_IRQ_CLR, 16'h003F);
      end
      wr(ADR_ALT, 16'h0055);
      wr(ADR_SCTL, 16'h000D);
      wtrans(8'h00, 8'h55, 1'b0);
      rchk(ADR_IRQ_STA, 16'h0030);
      rchk(ADR_SSTA, 16'h0007);
      wr(ADR_SCTL, 16'h001D);
      wr(ADR_SCTL, 16'h000D);
      rchk(ADR_SSTA, 16'h0000);
      wr(ADR_IRQ_CLR, 16'h003F);
      wr(ADR_SCTL, 16'h0005);
      wtrans(8'h00, 8'h55, 1'b0);
      rchk(ADR_IRQ_STA, 16'h0010);
      wr(ADR_SCTL, 16'h0009);
      wtrans(8'h00, 8'h55, 1'b1);
      give_verdict();
   end
endmodule : testbench
